// file: rtl/hbus_device.sv
// Device end: decodes host cycles into registers and two-entry data FIFOs
module hbus_device
  import hbus_pkg::*;
(
  input  wire logic              i_core_clk,  // Core clock
  input  wire logic              i_srst,      // Synchronous reset, active high
  hbus_if.device                 bus,         // Host pins
  output logic                   o_tx_valid,  // Transmit word available
  output logic [DATA_W-1:0]      o_tx_data,   // Transmit word
  input  wire logic              i_tx_ready,  // Consumer takes transmit word
  input  wire logic              i_rx_valid,  // Receive word offered
  input  wire logic [DATA_W-1:0] i_rx_data,   // Receive word
  output logic                   o_rx_ready   // Receive buffer has room
);

  // Whole state of the port
  // Everything that must survive a clock edge lives in this one struct, so
  // reset and the register stage stay a single assignment each
  typedef struct packed {
    dev_state_t                         state;   // Access state
    logic                               big;     // Byte order of this access
    logic [1:0]                         tx_v;    // Transmit entry valid
    logic [1:0][DATA_W-1:0]             tx_mem;  // Transmit entries, head at 0
    logic [1:0]                         rx_v;    // Receive entry valid
    logic [1:0][DATA_W-1:0]             rx_mem;  // Receive entries, head at 0
    logic                               rx_rdy;  // Receive room flag
    logic [REG_WORDS-1:0][DATA_W-1:0]   regs;    // Register words
    logic [DATA_W-1:0]                  dout;    // Data drive
    logic                               oe;      // Data enable
    logic                               ack;     // Access finished
  } dev_st_t;

  // Reset value: bus released, both buffers empty, receive side ready
  localparam dev_st_t ST_RESET = '{state: DEV_IDLE, rx_rdy: 1'b1, default: '0};

  // Present and next copy of the state
  dev_st_t st_q;   // Registered state
  dev_st_t st_d;   // Next state

  // Decoded view of the host pins in this cycle
  logic              sel;     // Select qualifies strobes
  logic              rd;      // Qualified read
  logic              wr;      // Qualified write
  logic [DATA_W-1:0] wdata;   // Write data in internal order
  logic [DATA_W-1:0] rdata;   // Read data in internal order
  logic              in_map;  // Address hits a register word

  // Next state of the whole port
  always_comb
  begin
    st_d   = st_q;
    // A strobe counts only while select is low; with select high the
    // device acts as if both strobes were released
    sel    = !bus.chip_select_low;
    rd     = sel && !bus.read_strobe_low;
    wr     = sel && !bus.write_strobe_low;
    // Incoming word put into internal byte order
    wdata  = order_bytes(bus.data, bus.big_end_sel);
    // Reads of nothing give the empty value
    rdata  = EMPTY_READ;
    // Register words sit at the bottom of the address space
    in_map = (bus.addr < ADDR_W'(REG_WORDS));

    // Consumer drains transmit head; worked out first so that a word
    // leaving now already frees room for a host push in this cycle
    if (st_q.tx_v[0] && i_tx_ready)
    begin
      // Second entry, if any, becomes the head
      st_d.tx_mem[0] = st_q.tx_mem[1];
      st_d.tx_v      = {1'b0, st_q.tx_v[1]};
    end

    // Producer fills receive buffer; the registered room flag keeps it
    // from ever overrunning the second entry
    if (i_rx_valid && st_q.rx_rdy)
    begin
      // Second entry when the head is already taken
      if (st_q.rx_v[0])
      begin
        st_d.rx_mem[1] = i_rx_data;
        st_d.rx_v[1]   = 1'b1;
      end
      else
      begin
        st_d.rx_mem[0] = i_rx_data;
        st_d.rx_v[0]   = 1'b1;
      end
    end

    // Access sequencer: take a strobe, answer, wait for its release
    unique case (st_q.state)
      // Wait for a qualified strobe
      DEV_IDLE:
      begin
        // Byte order of this access, fixed at the take edge
        st_d.big = bus.big_end_sel;
        // Reads win the decode; both strobes at once is a host fault
        if (rd)
        begin
          if (bus.fifo_sel)
          begin
            // Pop the receive head; empty reads give the empty value.
            // Next-state views let a word pushed in this same cycle
            // move up behind the popped head
            if (st_q.rx_v[0])
            begin
              rdata          = st_q.rx_mem[0];
              st_d.rx_mem[0] = st_d.rx_v[1] ? st_d.rx_mem[1] : st_d.rx_mem[0];
              st_d.rx_v      = {1'b0, st_d.rx_v[1]};
            end
          end
          // Status word is built from the live fill levels
          else if (bus.addr == STATUS_IDX)
          begin
            // Fill levels of both buffers, 0 to 2 entries each
            rdata[ST_TX_LSB +: 2] = {1'b0, st_q.tx_v[0]} + {1'b0, st_q.tx_v[1]};
            rdata[ST_RX_LSB +: 2] = {1'b0, st_q.rx_v[0]} + {1'b0, st_q.rx_v[1]};
          end
          // Words past the map keep the empty value
          else if (in_map)
          begin
            rdata = st_q.regs[bus.addr[3:0]];
          end
          // Answer in the byte order taken with this access
          st_d.dout  = order_bytes(rdata, st_d.big);
          st_d.oe    = 1'b1;
          st_d.ack   = 1'b1;
          st_d.state = DEV_DONE;
        end
        // Qualified write: FIFO push or register store
        else if (wr)
        begin
          if (bus.fifo_sel)
          begin
            // Hold the cycle until the transmit buffer has room; with no
            // answer given while full, the host simply waits
            if (!st_d.tx_v[1])
            begin
              // Append behind the head when one is waiting
              if (st_d.tx_v[0])
              begin
                st_d.tx_mem[1] = wdata;
                st_d.tx_v[1]   = 1'b1;
              end
              else
              begin
                st_d.tx_mem[0] = wdata;
                st_d.tx_v[0]   = 1'b1;
              end
              st_d.ack   = 1'b1;
              st_d.state = DEV_DONE;
            end
          end
          else
          begin
            // Whole word store; status and unmapped words drop it, but the
            // answer still comes so that no host cycle hangs
            if (in_map && bus.addr != STATUS_IDX)
            begin
              st_d.regs[bus.addr[3:0]] = wdata;
            end
            st_d.ack   = 1'b1;
            st_d.state = DEV_DONE;
          end
        end
      end

      // Hold answer until the strobe or select goes away; keeping the data
      // driven that long lets the host take it on the edge it sees the answer
      DEV_DONE:
      begin
        if (!(rd || wr))
        begin
          st_d.ack   = 1'b0;
          st_d.oe    = 1'b0;
          st_d.state = DEV_IDLE;
        end
      end
    endcase

    // Room flag from the next state, so it falls on the very edge that
    // fills the second entry
    st_d.rx_rdy = !st_d.rx_v[1];
  end

  // Register the state
  // Synchronous reset empties both buffers and releases the bus
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      st_q <= ST_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Every output is a field of the registered state, so none of them
  // can glitch with the host pins
  assign bus.dev_dout = st_q.dout;
  assign bus.dev_oe   = st_q.oe;
  assign bus.ack      = st_q.ack;
  assign o_tx_valid   = st_q.tx_v[0];
  assign o_tx_data    = st_q.tx_mem[0];
  assign o_rx_ready   = st_q.rx_rdy;

endmodule // hbus_device

// file: rtl/hbus_host.sv
// Host end: turns user requests into chip-selected strobe cycles
module hbus_host
  import hbus_pkg::*;
(
  input  wire logic              i_core_clk,   // Core clock
  input  wire logic              i_srst,       // Synchronous reset, active high
  hbus_if.host                   bus,          // Device pins
  input  wire logic              i_req,        // Start a cycle
  input  wire logic              i_write,      // Cycle is a write
  input  wire logic              i_fifo,       // Use FIFO direct access
  input  wire logic              i_big_end,    // Byte order select level
  input  wire logic [ADDR_W-1:0] i_addr,       // Word address
  input  wire logic [DATA_W-1:0] i_wdata,      // Write word
  output logic                   o_busy,       // Cycle in progress
  output logic [DATA_W-1:0]      o_rdata,      // Read word
  output logic                   o_rdata_valid // Read word pulse
);

  // Whole state of the host end
  typedef struct packed {
    host_state_t       state;   // Cycle state
    logic              write;   // Latched direction
    logic              cs_n;    // Select drive
    logic              rd_n;    // Read strobe drive
    logic              wr_n;    // Write strobe drive
    logic [ADDR_W-1:0] addr;    // Address drive
    logic              fifo;    // FIFO select drive
    logic              big;     // Byte order drive
    logic [DATA_W-1:0] dout;    // Data drive
    logic              oe;      // Data enable
    logic              busy;    // Busy flag
    logic [DATA_W-1:0] rdata;   // Captured read word
    logic              rvalid;  // Read word pulse
  } host_st_t;

  localparam host_st_t ST_RESET = '{state: HST_IDLE, cs_n: 1'b1, rd_n: 1'b1,
                                    wr_n: 1'b1, default: '0};

  host_st_t st_q;   // Registered state
  host_st_t st_d;   // Next state

  // Next state of the cycle sequencer
  always_comb
  begin
    st_d        = st_q;
    st_d.rvalid = 1'b0;
    unique case (st_q.state)
      // Present address, select and write data
      HST_IDLE:
      begin
        if (i_req)
        begin
          st_d.write = i_write;
          st_d.cs_n  = 1'b0;
          st_d.addr  = i_addr;
          st_d.fifo  = i_fifo;
          st_d.big   = i_big_end;
          st_d.dout  = i_wdata;
          st_d.oe    = i_write;
          st_d.busy  = 1'b1;
          st_d.state = HST_SETUP;
        end
      end
      // Assert exactly one strobe
      HST_SETUP:
      begin
        st_d.rd_n  = st_q.write;
        st_d.wr_n  = !st_q.write;
        st_d.state = HST_STROBE;
      end
      // Wait for the device to finish
      HST_STROBE:
      begin
        if (bus.ack)
        begin
          st_d.rdata  = bus.data;
          st_d.rvalid = !st_q.write;
          st_d.rd_n   = 1'b1;
          st_d.wr_n   = 1'b1;
          st_d.state  = HST_RELEASE;
        end
      end
      // Wait for the device to drop its answer, then deselect
      HST_RELEASE:
      begin
        if (!bus.ack)
        begin
          st_d.cs_n  = 1'b1;
          st_d.oe    = 1'b0;
          st_d.busy  = 1'b0;
          st_d.state = HST_IDLE;
        end
      end
    endcase
  end

  // Register the state
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      st_q <= ST_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign bus.chip_select_low  = st_q.cs_n;
  assign bus.read_strobe_low  = st_q.rd_n;
  assign bus.write_strobe_low = st_q.wr_n;
  assign bus.addr             = st_q.addr;
  assign bus.fifo_sel         = st_q.fifo;
  assign bus.big_end_sel      = st_q.big;
  assign bus.host_dout        = st_q.dout;
  assign bus.host_oe          = st_q.oe;
  assign o_busy               = st_q.busy;
  assign o_rdata              = st_q.rdata;
  assign o_rdata_valid        = st_q.rvalid;

endmodule // hbus_host

// file: rtl/hbus_if.sv
// Pin bundle joining the host end and the device end of the host bus
interface hbus_if;
  import hbus_pkg::*;

  logic              chip_select_low;   // Select, active low
  logic              read_strobe_low;   // Read strobe, active low
  logic              write_strobe_low;  // Write strobe, active low
  logic [ADDR_W-1:0] addr;              // Word address
  logic              fifo_sel;          // FIFO direct access select
  logic              big_end_sel;       // Byte order select
  logic [DATA_W-1:0] host_dout;         // Host data drive
  logic              host_oe;           // Host drives data
  logic [DATA_W-1:0] dev_dout;          // Device data drive
  logic              dev_oe;            // Device drives data
  logic              ack;               // Device finished the access
  logic [DATA_W-1:0] data;              // Resolved data bus level

  // Resolve the shared data wire from the two enables
  assign data = dev_oe ? dev_dout : (host_oe ? host_dout : BUS_IDLE);

  modport device (
    input  chip_select_low, read_strobe_low, write_strobe_low, addr, fifo_sel,
    input  big_end_sel, data,
    output dev_dout, dev_oe, ack
  );

  modport host (
    output chip_select_low, read_strobe_low, write_strobe_low, addr, fifo_sel,
    output big_end_sel, host_dout, host_oe,
    input  data, ack
  );
endinterface

// file: rtl/hbus_pkg.sv
// Shared constants and types for the host bus port and its host end
package hbus_pkg;

  localparam int unsigned DATA_W    = 16;                // Data bus width
  localparam int unsigned ADDR_W    = 9;                 // Word address width
  localparam int unsigned REG_WORDS = 16;                // Implemented register words

  localparam logic [ADDR_W-1:0] STATUS_IDX = 9'h000;     // Read-only buffer status word
  localparam int unsigned ST_TX_LSB = 0;                 // Transmit fill level field
  localparam int unsigned ST_RX_LSB = 8;                 // Receive fill level field
  localparam logic [DATA_W-1:0] EMPTY_READ = 16'h0000;   // Unmapped or empty read value
  localparam logic [DATA_W-1:0] BUS_IDLE   = 16'h0000;   // Undriven bus level

  // Access states of the device end
  typedef enum logic [0:0] {DEV_IDLE, DEV_DONE} dev_state_t;

  // Cycle states of the host end
  typedef enum logic [1:0] {HST_IDLE, HST_SETUP, HST_STROBE, HST_RELEASE} host_state_t;

  // Swap bytes when big endian ordering is selected
  function automatic logic [DATA_W-1:0] order_bytes(input logic [DATA_W-1:0] w,
                                                    input logic big);
    order_bytes = big ? {w[7:0], w[15:8]} : w;
  endfunction

endpackage

// file: testbench/hbus_sva.sv
// Pin checks between the host end and the device end
module hbus_sva
  import hbus_pkg::*;
(
  input wire logic              i_core_clk,       // Core clock
  input wire logic              i_srst,           // Sync reset
  input wire logic              chip_select_low,  // Select
  input wire logic              read_strobe_low,  // Read strobe
  input wire logic              write_strobe_low, // Write strobe
  input wire logic [ADDR_W-1:0] addr,             // Word address
  input wire logic              fifo_sel,         // FIFO select
  input wire logic              big_end_sel,      // Byte order
  input wire logic              host_oe,          // Host drives data
  input wire logic              dev_oe,           // Device drives data
  input wire logic              ack               // Access finished
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);

  // Strobes never overlap
  no_dual_strobe_a: assert property (read_strobe_low || write_strobe_low)
    else $error("both strobes low");
  // Strobes only inside a selected cycle
  strobe_in_cs_a: assert property (!(read_strobe_low && write_strobe_low)
    |-> !chip_select_low) else $error("strobe without select");
  // Answer only to a selected strobe
  ack_cause_a: assert property ($rose(ack) |-> $past(!chip_select_low) &&
    $past(!(read_strobe_low && write_strobe_low))) else $error("ack without access");
  // Read answered one cycle later with data driven
  read_answer_a: assert property ((!chip_select_low && !read_strobe_low && !ack)
    |=> ack && dev_oe) else $error("read not answered");
  // Register write answered one cycle later, bus left to host
  write_answer_a: assert property ((!chip_select_low && !write_strobe_low && !ack
    && !fifo_sel) |=> ack && !dev_oe) else $error("write not answered");
  // Answer drops after strobe release
  ack_release_a: assert property ((ack && read_strobe_low && write_strobe_low)
    |=> !ack && !dev_oe) else $error("ack stuck");
  // Host releases its strobe on the answer
  strobe_release_a: assert property ((ack && !(read_strobe_low && write_strobe_low))
    |=> read_strobe_low && write_strobe_low) else $error("strobe held");
  // Never two drivers on the data wire
  no_contention_a: assert property (!(dev_oe && host_oe))
    else $error("bus contention");
  // Address, mode and byte order held through a cycle
  held_fields_a: assert property ((!chip_select_low && $past(!chip_select_low)) |->
    $stable(addr) && $stable(fifo_sel) && $stable(big_end_sel)) else $error("fields moved");
endmodule // hbus_sva

// file: testbench/sram_like_host_bus_port_tb.sv
// Bench joining host end and device end across the host bus pins
module sram_like_host_bus_port_tb
  import hbus_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic              core_clk = 1'b0;  // Core clock
  logic              srst     = 1'b1;  // Sync reset
  logic              req      = 1'b0;  // Host request
  logic              wsel     = 1'b0;  // Cycle is a write
  logic              fifo     = 1'b0;  // FIFO access
  logic              big      = 1'b0;  // Byte order
  logic [ADDR_W-1:0] addr     = 9'h000;
  logic [DATA_W-1:0] wdata    = 16'h0000;
  logic              tx_ready = 1'b0;
  logic              rx_valid = 1'b0;
  logic [DATA_W-1:0] rx_data  = 16'h0000;
  logic              busy;
  logic              rdata_valid;
  logic              tx_valid;
  logic              rx_ready;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] tx_data;
  logic [DATA_W-1:0] got;              // Last read word
  int                fail_count = 0;
  int                compares   = 0;

  hbus_if link ();
  hbus_host hbus_host_inst (.i_core_clk(core_clk), .i_srst(srst), .bus(link.host),
    .i_req(req), .i_write(wsel), .i_fifo(fifo), .i_big_end(big), .i_addr(addr),
    .i_wdata(wdata), .o_busy(busy), .o_rdata(rdata), .o_rdata_valid(rdata_valid));
  hbus_device hbus_device_inst (.i_core_clk(core_clk), .i_srst(srst), .bus(link.device),
    .o_tx_valid(tx_valid), .o_tx_data(tx_data), .i_tx_ready(tx_ready),
    .i_rx_valid(rx_valid), .i_rx_data(rx_data), .o_rx_ready(rx_ready));
  hbus_sva hbus_sva_inst (.i_core_clk(core_clk), .i_srst(srst),
    .chip_select_low(link.chip_select_low), .read_strobe_low(link.read_strobe_low),
    .write_strobe_low(link.write_strobe_low), .addr(link.addr), .fifo_sel(link.fifo_sel),
    .big_end_sel(link.big_end_sel), .host_oe(link.host_oe), .dev_oe(link.dev_oe),
    .ack(link.ack));

  // Free running clock
  always #2 core_clk = ~core_clk;

  // Compare and report
  task automatic check(input logic [DATA_W-1:0] act, input logic [DATA_W-1:0] exp,
                       input string what);
    compares++;
    if (act !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, act, exp);
    end
  endtask

  // One host cycle; read word returned in rd
  task automatic access(input logic w, input logic f, input logic b,
                        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
                        output logic [DATA_W-1:0] rd);
    int n;
    @(posedge core_clk);
    #1;
    req = 1'b1;
    wsel = w;
    fifo = f;
    big = b;
    addr = a;
    wdata = wd;
    @(posedge core_clk);
    #1;
    req = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 60)
    begin
      if (rdata_valid === 1'b1)
        rd = rdata;
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n >= 60)
      check(16'h0000, 16'h0001, "host cycle hung");
  endtask

  // Pop one transmit word and compare it
  task automatic drain(input logic [DATA_W-1:0] exp);
    int n;
    n = 0;
    while (tx_valid !== 1'b1 && n < 30)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(tx_data, exp, "tx head");
    tx_ready = 1'b1;
    @(posedge core_clk);
    #1;
    tx_ready = 1'b0;
  endtask

  // Register words, byte order per access, unmapped and read-only words
  task automatic reg_test();
    access(1'b1, 1'b0, 1'b0, 9'h005, 16'h1234, got);
    access(1'b0, 1'b0, 1'b0, 9'h005, 16'h0000, got);
    check(got, 16'h1234, "word 5");
    access(1'b1, 1'b0, 1'b1, 9'h00F, 16'h12AB, got);
    access(1'b0, 1'b0, 1'b0, 9'h00F, 16'h0000, got);
    check(got, 16'hAB12, "big write little read");
    access(1'b0, 1'b0, 1'b1, 9'h00F, 16'h0000, got);
    check(got, 16'h12AB, "big read");
    access(1'b1, 1'b0, 1'b0, 9'h105, 16'hFFFF, got);
    access(1'b0, 1'b0, 1'b0, 9'h105, 16'h0000, got);
    check(got, EMPTY_READ, "unmapped read");
    access(1'b0, 1'b0, 1'b0, 9'h005, 16'h0000, got);
    check(got, 16'h1234, "no alias");
    access(1'b1, 1'b0, 1'b0, STATUS_IDX, 16'hFFFF, got);
    access(1'b0, 1'b0, 1'b0, STATUS_IDX, 16'h0000, got);
    check(got, 16'h0000, "status read-only");
  endtask

  // Transmit FIFO: fill until stall, drain with consumer stalling first
  task automatic tx_test();
    int n;
    access(1'b1, 1'b1, 1'b0, 9'h1FF, 16'hC001, got);
    access(1'b1, 1'b1, 1'b1, 9'h000, 16'hC002, got);
    access(1'b0, 1'b0, 1'b0, STATUS_IDX, 16'h0000, got);
    check(got, 16'h0002, "tx fill");
    fork
      access(1'b1, 1'b1, 1'b0, 9'h0AA, 16'hC003, got);
    join_none
    repeat (12) @(posedge core_clk);
    #1;
    check({15'h0000, busy}, 16'h0001, "full tx stalls");
    drain(16'hC001);
    drain(16'h02C0);
    drain(16'hC003);
    check({15'h0000, tx_valid}, 16'h0000, "tx empty");
    n = 0;
    while (busy !== 1'b0 && n < 30)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask

  // Receive FIFO: fill until refused, pop in both orders, read empty
  task automatic rx_test();
    rx_valid = 1'b1;
    rx_data = 16'h5A01;
    @(posedge core_clk);
    #1;
    rx_data = 16'h5A02;
    @(posedge core_clk);
    #1;
    rx_data = 16'h5A03;
    repeat (3) @(posedge core_clk);
    #1;
    check({15'h0000, rx_ready}, 16'h0000, "rx full");
    rx_valid = 1'b0;
    access(1'b0, 1'b1, 1'b0, 9'h003, 16'h0000, got);
    check(got, 16'h5A01, "rx pop");
    access(1'b0, 1'b1, 1'b1, 9'h005, 16'h0000, got);
    check(got, 16'h025A, "rx pop big");
    access(1'b0, 1'b1, 1'b0, 9'h005, 16'h0000, got);
    check(got, EMPTY_READ, "rx empty");
  endtask

  // Counts and verdict
  task automatic results();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (4) @(posedge core_clk);
    #1;
    srst = 1'b0;
    reg_test();
    tx_test();
    rx_test();
    results();
  end

  // Hang guard
  initial
  begin
    repeat (4000) @(posedge core_clk);
    fail_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    results();
  end
endmodule // sram_like_host_bus_port_tb
